// >>> core/epg_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts of the pin block.
// Assumes: Byte addresses on a 32-bit APB word map.
// Notes:   Definitions only; included by its bare name.
`ifndef EPG_DEFINES_SVH
`define EPG_DEFINES_SVH

// Register byte offsets.
`define EPG_CFG_OFFSET     12'h028
`define EPG_HWCFG_OFFSET   12'h040
`define EPG_STATUS_OFFSET  12'h044

// Field positions inside the pin configuration word.
`define EPG_FSEL_LSB       24
`define EPG_DRV_LSB        16
`define EPG_DIR_LSB        8
`define EPG_DATA_LSB       0

// Field positions inside the hardware configuration and status words.
`define EPG_MIRROR_BIT     0
`define EPG_STAT_MII_BIT   0
`define EPG_STAT_GPIN_LSB  8
`define EPG_STAT_ARM_LSB   16

// Reset values.
`define EPG_FSEL_RESET     8'hFF
`define EPG_DRV_RESET      8'h00
`define EPG_DIR_RESET      8'h00
`define EPG_MIRROR_RESET   1'h0

// Cycles after reset release before synchronised pin levels are trusted.
`define EPG_SETTLE_CYCLES  2'h2

`endif

// >>> core/epg_pkg.sv
// Purpose: Shared types of the pin block.
// Assumes: Nothing beyond the defines header.
// Notes:   Constants live in the defines header; types live here.
package epg_pkg;

  // Start-up sequence: wait for synchronisers, capture pin levels, run.
  typedef enum logic [1:0] {
    epg_settle,
    epg_capture,
    epg_run
  } epg_phase_t;

endpackage : epg_pkg

// >>> core/epg_sync.sv
// Purpose: Two-flop synchroniser for a vector of asynchronous pin levels.
// Assumes: Each bit is independent; no bus coherence is needed.
// Notes:   The first stage is read by the second stage only.
`timescale 1ns/1ns

module epg_sync #(
  parameter int W = 8
) (
  input  wire logic         pclk,     // Core clock.
  input  wire logic         presetn,  // Asynchronous reset, active low.
  input  wire logic [W-1:0] async_in, // Raw levels from the pins.
  output logic      [W-1:0] sync_out  // Levels safe to use on pclk.
);

  logic [W-1:0] stage1;

  // Two stages give metastability time to resolve before any logic looks.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : epg_sync

// >>> core/epg_pad_drive.sv
// Purpose: Registered per-pin output and enable for the eight general pins.
// Assumes: Inputs are on pclk; default-function pins are driven here only with mirrored MII signals.
// Notes:   An enable of one means this block drives the pin.
`timescale 1ns/1ns

module epg_pad_drive #(
  parameter int W = 8
) (
  input  wire logic         pclk,        // Core clock.
  input  wire logic         presetn,     // Asynchronous reset, active low.
  input  wire logic         withdrawn,   // External MII mode owns the pins.
  input  wire logic [W-1:0] gp_mode,     // Pin is in general-purpose use.
  input  wire logic [W-1:0] dir_out,     // Pin is an output.
  input  wire logic [W-1:0] push_pull,   // Push-pull when set, open-drain when clear.
  input  wire logic [W-1:0] out_value,   // Written output value.
  input  wire logic         mirror_en,   // Mirror internal MII onto idle pins.
  input  wire logic [W-1:0] mirror_val,  // Internal MII signals to mirror.
  output logic      [W-1:0] pad_out,     // Pin output level.
  output logic      [W-1:0] pad_oe       // Pin output enable.
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_pin
      // Each pin is driven from a flop so the pad sees no decode glitches.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pad_out[i] <= 1'h0;
          pad_oe[i]  <= 1'h0;
        end else if (withdrawn) begin
          pad_out[i] <= 1'h0;
          pad_oe[i]  <= 1'h0;
        end else if (gp_mode[i] && dir_out[i]) begin
          if (push_pull[i]) begin
            pad_out[i] <= out_value[i];
            pad_oe[i]  <= 1'h1;
          end else begin
            pad_out[i] <= 1'h0;
            pad_oe[i]  <= ~out_value[i];
          end
        end else if (!gp_mode[i] && mirror_en) begin
          pad_out[i] <= mirror_val[i];
          pad_oe[i]  <= 1'h1;
        end else begin
          pad_out[i] <= 1'h0;
          pad_oe[i]  <= 1'h0;
        end
      end
    end
  endgenerate

endmodule : epg_pad_drive

// >>> core/epg_gpio_cfg.sv
// Purpose: Configuration, data and wake gating for eight general-purpose pins.
// Assumes: APB3 slave on pclk; pins and strap are asynchronous to pclk.
// Notes:   Reads of the data field return live pin levels, not stored values.
//
// Notes on behaviour
// - External MII mode withdraws all eight pins.
// - Wake or interrupt only from input pins.
// - Wake also needs its wake enable bit.
// - Function select bits 31:24, reset FFh.
// - Idle pins may mirror internal MII signals.
// - Pins start non-general after any reset.
// - Driver type bits 23:16, set is push-pull.
// - Direction bits 15:8, set is output.
// - Output pins drive last written data bit; a write in epg_settle is replaced by pin levels at capture.
// - Data reads return sampled pin levels.
// - Data after reset follows pin levels.
// - Config register is word at 028h.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ns
`include "epg_defines.svh"

module epg_gpio_cfg #(
  parameter int AW = 12
) (
  input  wire logic          pclk,              // Core clock, 50 MHz.
  input  wire logic          presetn,           // Asynchronous reset, active low.
  input  wire logic          psel,              // APB select.
  input  wire logic          penable,           // APB access phase.
  input  wire logic          pwrite,            // APB write when high.
  input  wire logic [AW-1:0] paddr,             // APB byte address.
  input  wire logic [31:0]   pwdata,            // APB write data.
  output logic      [31:0]   prdata,            // APB read data.
  output logic               pready,            // APB ready.
  output logic               pslverr,           // APB error on unmapped address.
  input  wire logic [7:0]    pin_in,            // Pin levels from the pads.
  output logic      [7:0]    pin_out,           // Pin output levels.
  output logic      [7:0]    pin_oe,            // Pin output enables.
  input  wire logic          phy_select_strap,  // Strap; high selects external MII.
  input  wire logic [7:0]    wake_enable_bits,  // Wake enables from the wake register.
  input  wire logic [7:0]    wake_polarity_bits,// Wake active level, one is high.
  input  wire logic [7:0]    mii_mirror_in,     // Internal MII signals for mirroring.
  output logic      [7:0]    wake_event,        // One-cycle wake pulse per pin.
  output logic      [7:0]    irq_source,        // One-cycle interrupt source pulse per pin.
  output logic               external_mii_mode  // Pins withdrawn by the strap.
);

  // Word decode, shared by every register access.
  function automatic logic epg_hit(input logic [AW-1:0] addr,
                                   input logic [11:0]   offset);
    epg_hit = (addr[AW-1:2] == offset[AW-1:2]);
  endfunction : epg_hit

  // Configuration state.
  logic [7:0]  pin_function_select;
  logic [7:0]  output_drive_type;
  logic [7:0]  pin_direction;
  logic [7:0]  pin_value;
  logic        internal_mii_mirror_enable;

  // Start-up and pin sampling state.
  epg_pkg::epg_phase_t phase;
  logic [1:0]  settle_count;
  logic [7:0]  pin_level;
  logic [7:0]  pin_level_prev;
  logic        strap_level;

  // Bus decode terms.
  logic        setup_phase;
  logic        access_done;
  logic        wr_done;
  logic        hit_cfg;
  logic        hit_hwcfg;
  logic        hit_status;
  logic        hit_any;

  // Derived pin terms.
  logic [7:0]  gp_mode;
  logic [7:0]  gp_input;
  logic [7:0]  active_now;
  logic [7:0]  active_prev;
  logic [7:0]  active_edge;
  logic [31:0] next_prdata;

  // Pins and strap come from outside the clock domain.
  epg_sync #(
    .W (8)
  ) u_pin_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (pin_in),
    .sync_out (pin_level)
  );

  epg_sync #(
    .W (1)
  ) u_strap_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (phy_select_strap),
    .sync_out (strap_level)
  );

  // Setup cycle starts an access; the access completes where pready is sampled high.
  assign setup_phase = psel && !penable;
  assign access_done = psel && penable && pready;
  assign wr_done     = access_done && pwrite;

  // Address decode of the three words.
  assign hit_cfg    = epg_hit(paddr, `EPG_CFG_OFFSET);
  assign hit_hwcfg  = epg_hit(paddr, `EPG_HWCFG_OFFSET);
  assign hit_status = epg_hit(paddr, `EPG_STATUS_OFFSET);
  assign hit_any    = hit_cfg || hit_hwcfg || hit_status;

  // A pin is general-purpose only when its select bit is clear and MII is not selected.
  assign gp_mode  = ~pin_function_select & {8{~external_mii_mode}};
  assign gp_input = gp_mode & ~pin_direction;

  // Edge of each pin into its active level, as set by the wake polarity.
  assign active_now  = ~(pin_level ^ wake_polarity_bits);
  assign active_prev = ~(pin_level_prev ^ wake_polarity_bits);
  assign active_edge = active_now & ~active_prev;

  // Start-up sequencer: synchronisers need two edges before their output is real.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase        <= epg_pkg::epg_settle;
      settle_count <= 2'h0;
    end else begin
      case (phase)
        epg_pkg::epg_settle: begin
          if (settle_count == `EPG_SETTLE_CYCLES - 2'h1) begin
            phase <= epg_pkg::epg_capture;
          end else begin
            settle_count <= settle_count + 2'h1;
          end
        end
        epg_pkg::epg_capture: begin
          phase <= epg_pkg::epg_run;
        end
        epg_pkg::epg_run: begin
          phase <= epg_pkg::epg_run;
        end
        default: begin
          phase <= epg_pkg::epg_settle;
        end
      endcase
    end
  end

  // The strap is latched once after release; until then the pins stay withdrawn.
  // Holding withdrawn by default avoids driving pins an external PHY may own.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      external_mii_mode <= 1'h1;
    end else if (phase == epg_pkg::epg_capture) begin
      external_mii_mode <= strap_level;
    end
  end

  // Function select field; every pin leaves reset in its default function.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_function_select <= `EPG_FSEL_RESET;
    end else if (wr_done && hit_cfg) begin
      pin_function_select <= pwdata[`EPG_FSEL_LSB +: 8];
    end
  end

  // Output driver type field.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_drive_type <= `EPG_DRV_RESET;
    end else if (wr_done && hit_cfg) begin
      output_drive_type <= pwdata[`EPG_DRV_LSB +: 8];
    end
  end

  // Direction field; all pins start as inputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_direction <= `EPG_DIR_RESET;
    end else if (wr_done && hit_cfg) begin
      pin_direction <= pwdata[`EPG_DIR_LSB +: 8];
    end
  end

  // Stored output value. The flop needs a constant under reset, so the pin
  // levels are loaded once the synchronisers have settled; a write in that
  // same cycle wins because software asked for that value explicitly.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_value <= 8'h00;
    end else if (wr_done && hit_cfg) begin
      pin_value <= pwdata[`EPG_DATA_LSB +: 8];
    end else if (phase == epg_pkg::epg_capture) begin
      pin_value <= pin_level;
    end
  end

  // Mirror control bit in the hardware configuration word.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      internal_mii_mirror_enable <= `EPG_MIRROR_RESET;
    end else if (wr_done && hit_hwcfg) begin
      internal_mii_mirror_enable <= pwdata[`EPG_MIRROR_BIT];
    end
  end

  // Previous pin level for edge detection; taken from the synchronised copy only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_level_prev <= 8'h00;
    end else begin
      pin_level_prev <= pin_level;
    end
  end

  // Wake and interrupt pulses. Output pins and pins in their default
  // function never raise them, so a driven pin cannot wake the device itself.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_event <= 8'h00;
      irq_source <= 8'h00;
    end else if (phase != epg_pkg::epg_run) begin
      wake_event <= 8'h00;
      irq_source <= 8'h00;
    end else begin
      irq_source <= active_edge & gp_input;
      wake_event <= active_edge & gp_input & wake_enable_bits;
    end
  end

  // Read data assembly; reserved and unmapped bits read as zero.
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (hit_cfg) begin
      next_prdata[`EPG_FSEL_LSB +: 8] = pin_function_select;
      next_prdata[`EPG_DRV_LSB +: 8]  = output_drive_type;
      next_prdata[`EPG_DIR_LSB +: 8]  = pin_direction;
      next_prdata[`EPG_DATA_LSB +: 8] = pin_level;
    end else if (hit_hwcfg) begin
      next_prdata[`EPG_MIRROR_BIT] = internal_mii_mirror_enable;
    end else if (hit_status) begin
      next_prdata[`EPG_STAT_MII_BIT]       = external_mii_mode;
      next_prdata[`EPG_STAT_GPIN_LSB +: 8] = gp_input;
      next_prdata[`EPG_STAT_ARM_LSB +: 8]  = gp_input & wake_enable_bits;
    end
  end

  // APB answer: ready and data are registered in the setup cycle, so every
  // access finishes on its first access-phase edge with no wait state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'h0;
      pslverr <= 1'h0;
      prdata  <= 32'h0000_0000;
    end else if (setup_phase) begin
      pready  <= 1'h1;
      pslverr <= ~hit_any;
      prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
    end else begin
      pready  <= 1'h0;
      pslverr <= 1'h0;
    end
  end

  // Pad drivers; registered so the pin outputs come straight from flops.
  epg_pad_drive #(
    .W (8)
  ) u_pad (
    .pclk       (pclk),
    .presetn    (presetn),
    .withdrawn  (external_mii_mode),
    .gp_mode    (gp_mode),
    .dir_out    (pin_direction),
    .push_pull  (output_drive_type),
    .out_value  (pin_value),
    .mirror_en  (internal_mii_mirror_enable),
    .mirror_val (mii_mirror_in),
    .pad_out    (pin_out),
    .pad_oe     (pin_oe)
  );

endmodule : epg_gpio_cfg

// >>> tb/epg_gpio_cfg_assertions.sv
// Purpose: Concurrent checks on the pin block's ports.
// Assumes: One clock domain; asynchronous reset, active low.
// Notes:   Bound from the bench top file.
`timescale 1ns/1ns
`include "epg_defines.svh"

module epg_gpio_cfg_assertions #(
  parameter int AW = 12
) (
  input wire logic          pclk,               // Clock.
  input wire logic          presetn,            // Reset.
  input wire logic          psel,               // Select.
  input wire logic          penable,            // Access.
  input wire logic          pwrite,             // Write.
  input wire logic [AW-1:0] paddr,              // Address.
  input wire logic [31:0]   pwdata,             // Write data.
  input wire logic [31:0]   prdata,             // Read data.
  input wire logic          pready,             // Ready.
  input wire logic          pslverr,            // Error.
  input wire logic [7:0]    pin_in,             // Pin levels.
  input wire logic [7:0]    pin_out,            // Pin outputs.
  input wire logic [7:0]    pin_oe,             // Pin enables.
  input wire logic          phy_select_strap,   // Strap.
  input wire logic [7:0]    wake_enable_bits,   // Wake enables.
  input wire logic [7:0]    wake_polarity_bits, // Wake levels.
  input wire logic [7:0]    mii_mirror_in,      // Mirror source.
  input wire logic [7:0]    wake_event,         // Wake pulses.
  input wire logic [7:0]    irq_source,         // Interrupt pulses.
  input wire logic          external_mii_mode   // Pins withdrawn.
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [31:0] last_cfg; // Last configuration word written.
  logic        setup;    // Setup cycle of a transfer.
  logic        mapped;   // Address decodes to a register.
  logic        wr_cfg;   // Write to the configuration takes effect.

  // Decode helpers; the bench only issues aligned addresses.
  assign setup  = psel && !penable;
  assign mapped = paddr == `EPG_CFG_OFFSET || paddr == `EPG_HWCFG_OFFSET
                  || paddr == `EPG_STATUS_OFFSET;
  assign wr_cfg = psel && penable && pready && pwrite && paddr == `EPG_CFG_OFFSET;

  // Keep the written word so the drive check can look two edges later.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_cfg <= 32'h0;
    end else if (wr_cfg) begin
      last_cfg <= pwdata;
    end
  end

  AST_PREADY_SETUP: assert property (setup |=> pready)
    else $error("ready missing after setup");
  AST_PREADY_ACCESS: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  AST_UNMAPPED: assert property (setup && !mapped |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  AST_MAPPED_OK: assert property (setup && mapped |=> !pslverr)
    else $error("mapped access refused");
  AST_EXT_WITHDRAW: assert property (external_mii_mode |-> pin_oe == 8'h00)
    else $error("pin driven in external mode");
  AST_EXT_QUIET: assert property (external_mii_mode |-> (wake_event | irq_source) == 8'h00)
    else $error("pulse in external mode");
  AST_WAKE_ENABLED: assert property (
    (wake_event & ~wake_enable_bits & ~$past(wake_enable_bits)) == 8'h00)
    else $error("wake on disabled pin");
  AST_WAKE_WITH_IRQ: assert property ((wake_event & ~irq_source) == 8'h00)
    else $error("wake without source pulse");
  AST_GP_DRIVE: assert property (wr_cfg && !external_mii_mode |-> ##2 (
    ((pin_oe ^ (last_cfg[23:16] | ~last_cfg[7:0])) & ~last_cfg[31:24] & last_cfg[15:8]) == 8'h0
    && ((pin_out ^ (last_cfg[23:16] & last_cfg[7:0])) & ~last_cfg[31:24] & last_cfg[15:8])
    == 8'h0)) else $error("general output drive wrong");
endmodule : epg_gpio_cfg_assertions

// >>> tb/epg_pin_board.sv
// Purpose: Board seen by the eight pins.
// Assumes: The board drives every pin the block releases.
// Notes:   No contention is modelled.
`timescale 1ns/1ns

module epg_pin_board (
  input  wire logic [7:0] pin_out,  // Levels the block drives.
  input  wire logic [7:0] pin_oe,   // Enables of the block.
  input  wire logic [7:0] ext_val,  // Board levels on released pins.
  output logic      [7:0] pin_level // Resolved wire levels.
);
  // A released pin shows the board level, never the last driven one.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_level[i] = pin_oe[i] ? pin_out[i] : ext_val[i];
    end
  end
endmodule : epg_pin_board

// >>> tb/epg_gpio_cfg_tb.sv
// Purpose: Self-checking bench for the pin configuration block.
// Assumes: APB master per the hand-over timing; board model on the pins.
// Notes:   Expectations come from a small model of the fields.
`timescale 1ns/1ns
`include "epg_defines.svh"

module epg_gpio_cfg_tb;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, rv;
  logic        pready, pslverr, strap = 1'b0, ext_mode, err;
  logic [7:0]  pin_in, pin_out, pin_oe, ext_val = 8'h5A, wen = 8'h00, mii = 8'h00;
  logic [7:0]  wake, irq;
  int          error_cnt = 0, samples_checked = 0, cyc = 0, seed = 32'hf577;

  always #10 pclk = ~pclk;

  epg_gpio_cfg dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .phy_select_strap(strap), .wake_enable_bits(wen), .wake_polarity_bits(8'hFF),
    .mii_mirror_in(mii), .wake_event(wake), .irq_source(irq), .external_mii_mode(ext_mode));
  epg_pin_board u_board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
    .pin_level(pin_in));

  // A hang ends the run as a failure.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Request held until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rst_dut();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
  endtask : rst_dut

  // Enables: general outputs by driver type, mirrored pins when not general.
  function automatic logic [7:0] m_oe(input logic [31:0] c, input logic m);
    return (~c[31:24] & c[15:8] & (c[23:16] | ~c[7:0])) | (m ? c[31:24] : 8'h00);
  endfunction : m_oe

  function automatic logic [7:0] m_out(input logic [31:0] c, input logic m, input logic [7:0] v);
    return (~c[31:24] & c[15:8] & c[23:16] & c[7:0]) | (m ? (c[31:24] & v) : 8'h00);
  endfunction : m_out

  initial begin : main
    logic [31:0] c;
    logic [7:0]  oe, ov, acc_i, acc_w;
    rst_dut();
    @(negedge pclk);
    chk({ext_mode, pin_oe}, 9'h000);
    apb(1'b0, `EPG_CFG_OFFSET, 32'h0);
    chk(rd, 32'hFF00005A);
    $display("TEST reset_values done");
    // Random configurations, with and without mirroring.
    for (int k = 0; k < 16; k++) begin
      c = $random(seed);
      rv = $random(seed);
      @(posedge pclk);
      mii <= rv[15:8];
      ext_val <= rv[23:16];
      apb(1'b1, `EPG_HWCFG_OFFSET, {31'h0, rv[0]});
      apb(1'b1, `EPG_CFG_OFFSET, c);
      repeat (4) @(posedge pclk);
      oe = m_oe(c, rv[0]);
      ov = m_out(c, rv[0], rv[15:8]);
      @(negedge pclk);
      chk(pin_oe, oe);
      chk(pin_out & oe, ov & oe);
      apb(1'b1, 12'h02C, 32'h0);
      apb(1'b0, `EPG_CFG_OFFSET, 32'h0);
      chk(rd, {c[31:8], (oe & ov) | (~oe & rv[23:16])});
    end
    apb(1'b0, 12'h030, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    $display("TEST config_random done");
    // Pins 4 to 7 are released open-drain outputs and must not raise events.
    @(posedge pclk);
    ext_val <= 8'h00;
    wen <= 8'h35;
    apb(1'b1, `EPG_HWCFG_OFFSET, 32'h0);
    apb(1'b1, `EPG_CFG_OFFSET, 32'h0000F0FF);
    repeat (6) @(posedge pclk);
    ext_val <= 8'hFF;
    acc_i = 8'h00;
    acc_w = 8'h00;
    repeat (10) begin
      @(negedge pclk);
      acc_i = acc_i | irq;
      acc_w = acc_w | wake;
    end
    chk(acc_i, 8'h0F);
    chk(acc_w, 8'h05);
    $display("TEST wake_gating done");
    // External mode after a second reset withdraws every pin.
    @(posedge pclk);
    strap <= 1'b1;
    rst_dut();
    apb(1'b0, `EPG_CFG_OFFSET, 32'h0);
    chk({ext_mode, rd[31:8]}, 25'h1FF0000);
    apb(1'b1, `EPG_HWCFG_OFFSET, 32'h1);
    apb(1'b1, `EPG_CFG_OFFSET, 32'h00FFFF55);
    repeat (4) @(posedge pclk);
    @(negedge pclk);
    chk(pin_oe, 8'h00);
    $display("TEST external_mode done");
    stop_test();
  end
endmodule : epg_gpio_cfg_tb

bind epg_gpio_cfg epg_gpio_cfg_assertions #(.AW(AW)) u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
  .pin_oe(pin_oe), .phy_select_strap(phy_select_strap), .wake_enable_bits(wake_enable_bits),
  .wake_polarity_bits(wake_polarity_bits), .mii_mirror_in(mii_mirror_in),
  .wake_event(wake_event), .irq_source(irq_source), .external_mii_mode(external_mii_mode));
